// File: gas_alias_regs.sv
// APB register block for the secure-side group 1 alias registers of a CPU interface.
// What this block does
// RL1: Split setting divides the 8-bit priority into group and subpriority parts.
// RL2: Group 1 with common split and grouping uses its own split rule.
// RL3: Alias split register is the non-secure split register itself.
// RL4: Acknowledge read returns the group 1 interrupt ID in bits 9:0.
// RL5: Each acknowledge read acknowledges the returned interrupt.
// RL6: With security extensions, acknowledge alias answers secure accesses only.
// RL7: Secure alias acknowledge read equals a non-secure ordinary acknowledge read.
// RL8: For software interrupts, bits 12:10 return the requesting CPU interface.
// RL9: Source field reads zero for all other interrupts.
// RL10: With acknowledge control 0, a write drops priority of the written interrupt.
// RL11: If the applicable end mode bit is 0, the write also deactivates.
// RL12: Alias end write serves group 1 active priorities, not group 0.
// RL13: Software writes only the most recently acknowledged group 1 interrupt.
// RL14: Secure alias end write uses the secure end mode bit.
// RL15: Software writes the returned source value for software interrupts, else zero.
// RL16: Software writes the returned interrupt ID into bits 9:0.
// RL17: Writing any other value gives undefined results.
// RL18: Split register resets to the minimum split value plus one.
// RL19: Reserved bits read zero and ignore writes.
`default_nettype none
module gas_alias_regs
    import gas_pkg::*;
#(
    parameter bit         SECURITY_EXT = 1'b1,
    parameter bit         MULTI_CPU    = 1'b1,
    parameter logic [2:0] MIN_SPLIT    = GAS_MIN_SPLIT_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [2:0]  pprot,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pend_valid,
    input  wire logic        pend_group1,
    input  wire logic [9:0]  pend_id,
    input  wire logic [2:0]  pend_source,
    input  wire logic [7:0]  pend_priority,
    output logic             ack_pulse,
    output logic      [9:0]  ack_id,
    output logic      [2:0]  ack_source,
    output logic             drop_pulse,
    output logic             deactivate_pulse,
    output logic      [9:0]  eos_id,
    output logic      [2:0]  eos_source,
    output logic      [7:0]  group_priority
);
    initial begin
        if (MIN_SPLIT > 3'h3) begin
            $error("MIN_SPLIT must be 0 to 3");
        end
    end

    typedef struct packed {
        logic [2:0]  split;
        logic [3:0]  ctrl;
        logic [31:0] rdata;
        logic        ack;
        logic [9:0]  ack_id;
        logic [2:0]  ack_src;
        logic        drop;
        logic        deact;
        logic [9:0]  eos_id;
        logic [2:0]  eos_src;
        logic [9:0]  last_id;
        logic [2:0]  last_src;
        logic        mismatch;
    } gas_state_t;

    gas_state_t st_r;
    gas_state_t st_nxt;
    logic       access;
    logic       secure;
    logic       hit;
    logic       grp_en;
    logic [9:0] rd_id;
    logic [2:0] rd_src;

    assign access = psel & penable;
    assign secure = ~pprot[1];
    assign pready = 1'b1;

    gas_split_mask u_mask (
        .split          (st_r.split),
        .group1_rule    (st_r.ctrl[GAS_CTRL_COMMON] & st_r.ctrl[GAS_CTRL_GROUPING] & pend_group1), // RL2
        .priority_in    (pend_priority),
        .group_priority (group_priority)
    );

    always_comb begin
        // Only a group 1 interrupt is visible here, as for a non-secure ordinary read.
        grp_en = pend_valid & pend_group1; // RL7
        rd_id  = grp_en ? pend_id : GAS_SPURIOUS_ID; // RL4
        rd_src = (MULTI_CPU && grp_en && pend_id < GAS_SGI_LIMIT) ? pend_source : 3'h0; // RL8 RL9
        hit    = 1'b1;
        st_nxt       = st_r;
        st_nxt.ack   = 1'b0;
        st_nxt.drop  = 1'b0;
        st_nxt.deact = 1'b0;
        // With SECURITY_EXT, non-secure accesses see the alias offsets as absent: read zero, ignored.
        if (access && SECURITY_EXT && !secure && paddr != GAS_OFF_CTRL && paddr != GAS_OFF_STATUS) begin // RL6
            hit = 1'b0;
        end
        if (access && hit) begin
            st_nxt.rdata = 32'h0000_0000; // RL19
            unique case (paddr)
                GAS_OFF_SPLIT: begin
                    if (pwrite) begin
                        st_nxt.split = (pwdata[2:0] < MIN_SPLIT + 3'h1) ? MIN_SPLIT + 3'h1 : pwdata[2:0]; // RL3
                    end else begin
                        st_nxt.rdata[2:0] = st_r.split; // RL19
                    end
                end
                GAS_OFF_ACK: begin
                    if (!pwrite) begin
                        st_nxt.rdata[GAS_ID_LSB +: GAS_ID_W]   = rd_id; // RL4
                        st_nxt.rdata[GAS_SRC_LSB +: GAS_SRC_W] = rd_src; // RL8
                        if (grp_en) begin
                            st_nxt.ack      = 1'b1; // RL5
                            st_nxt.ack_id   = rd_id;
                            st_nxt.ack_src  = rd_src;
                            st_nxt.last_id  = rd_id;
                            st_nxt.last_src = rd_src;
                        end
                    end
                end
                GAS_OFF_EOS: begin
                    if (pwrite && !st_r.ctrl[GAS_CTRL_ACKNOWLEDGE_CONTROL]) begin // RL10
                        // Group 1 bookkeeping only; group 0 priorities are never touched.
                        st_nxt.drop     = 1'b1; // RL12
                        st_nxt.deact    = ~st_r.ctrl[GAS_CTRL_SECURE_END_SERVICE_MODE]; // RL11 RL14
                        st_nxt.eos_id   = pwdata[GAS_ID_LSB +: GAS_ID_W]; // RL16
                        st_nxt.eos_src  = pwdata[GAS_SRC_LSB +: GAS_SRC_W]; // RL15
                        // Mismatch is flagged for debug; the outcome is left undefined.
                        st_nxt.mismatch = (pwdata[9:0] != st_r.last_id) ||
                                          (pwdata[12:10] != st_r.last_src); // RL13 RL17
                    end
                end
                GAS_OFF_CTRL: begin
                    if (pwrite) begin
                        st_nxt.ctrl = pwdata[3:0];
                    end else begin
                        st_nxt.rdata[3:0] = st_r.ctrl;
                    end
                end
                GAS_OFF_STATUS: begin
                    if (!pwrite) begin
                        st_nxt.rdata[12:0] = {st_r.last_src, st_r.last_id};
                        st_nxt.rdata[16]   = st_r.mismatch;
                    end
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end else if (access) begin
            st_nxt.rdata = 32'h0000_0000; // RL6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            st_r.split    <= MIN_SPLIT + 3'h1; // RL18
            st_r.ctrl     <= GAS_CTRL_RESET;
            st_r.last_id  <= GAS_SPURIOUS_ID;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read data goes out combinationally from the access cycle so pready can stay high.
    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite && hit) begin
            unique case (paddr)
                GAS_OFF_SPLIT:  prdata[2:0] = st_r.split;
                GAS_OFF_ACK:    prdata[12:0] = {rd_src, rd_id};
                GAS_OFF_CTRL:   prdata[3:0] = st_r.ctrl;
                GAS_OFF_STATUS: prdata = {15'h0000, st_r.mismatch, 3'h0, st_r.last_src, st_r.last_id};
                default:        prdata = 32'h0000_0000;
            endcase
        end
    end

    assign pslverr          = 1'b0;
    assign ack_pulse        = st_r.ack;
    assign ack_id           = st_r.ack_id;
    assign ack_source       = st_r.ack_src;
    assign drop_pulse       = st_r.drop;
    assign deactivate_pulse = st_r.deact;
    assign eos_id           = st_r.eos_id;
    assign eos_source       = st_r.eos_src;
endmodule // gas_alias_regs
`default_nettype wire

// File: gas_pkg.sv
// Constants shared by the group 1 alias register block.
`default_nettype none
package gas_pkg;
    localparam logic [11:0] GAS_OFF_SPLIT     = 12'h000;
    localparam logic [11:0] GAS_OFF_ACK       = 12'h004;
    localparam logic [11:0] GAS_OFF_EOS       = 12'h008;
    localparam logic [11:0] GAS_OFF_CTRL      = 12'h00c;
    localparam logic [11:0] GAS_OFF_STATUS    = 12'h010;
    localparam int          GAS_SPLIT_W       = 3;
    localparam int          GAS_ID_LSB        = 0;
    localparam int          GAS_ID_W          = 10;
    localparam int          GAS_SRC_LSB       = 10;
    localparam int          GAS_SRC_W         = 3;
    localparam logic [2:0]  GAS_MIN_SPLIT_DEF = 3'h0;
    localparam logic [9:0]  GAS_SPURIOUS_ID   = 10'h3ff;
    localparam logic [9:0]  GAS_SGI_LIMIT     = 10'h010;
    localparam int          GAS_CTRL_COMMON   = 0;
    localparam int          GAS_CTRL_ACKNOWLEDGE_CONTROL   = 1;
    localparam int          GAS_CTRL_SECURE_END_SERVICE_MODE = 2;
    localparam int          GAS_CTRL_GROUPING = 3;
    localparam logic [3:0]  GAS_CTRL_RESET    = 4'h8;
endpackage : gas_pkg
`default_nettype wire

// File: gas_split_mask.sv
// Converts a split setting into a group priority mask for one 8-bit priority.
`default_nettype none
module gas_split_mask
    import gas_pkg::*;
(
    input  wire logic [2:0] split,
    input  wire logic       group1_rule,
    input  wire logic [7:0] priority_in,
    output logic      [7:0] group_priority
);
    logic [2:0] eff;
    logic [7:0] mask;

    // Group 1 under the common and grouping settings uses the split one lower, saturating at zero.
    always_comb begin
        eff  = (group1_rule && split != 3'h0) ? split - 3'h1 : split; // RL2
        mask = 8'hfe << eff; // RL1
        group_priority = priority_in & mask; // RL1
    end
endmodule // gas_split_mask
`default_nettype wire

// File: gas_monitor.sv
// Checker for the group 1 alias register block, bound to its top module.
`default_nettype none
module gas_monitor
    import gas_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0]  pprot,
    input wire logic [31:0] prdata,
    input wire logic        pend_valid,
    input wire logic        pend_group1,
    input wire logic [9:0]  pend_id,
    input wire logic        ack_pulse,
    input wire logic [9:0]  ack_id,
    input wire logic        drop_pulse,
    input wire logic        deactivate_pulse,
    input wire logic [9:0]  eos_id
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_ack;
    logic g1;
    assign rd_ack = psel && penable && !pwrite && paddr == GAS_OFF_ACK;
    assign g1 = pend_valid && pend_group1;
    property p_id; rd_ack && !pprot[1] && g1 |-> prdata[9:0] == pend_id && prdata[31:13] == 19'h0; endproperty
    a_id: assert property (p_id) else $error("ack id wrong");
    property p_ack; rd_ack && !pprot[1] && g1 |=> ack_pulse && ack_id == $past(pend_id); endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_src; rd_ack && pend_id >= GAS_SGI_LIMIT |-> prdata[12:10] == 3'h0; endproperty
    a_src: assert property (p_src) else $error("source not zero");
    property p_ns; rd_ack && pprot[1] |-> prdata == 32'h0 ##1 !ack_pulse; endproperty
    a_ns: assert property (p_ns) else $error("non-secure ack");
    property p_none; rd_ack && !pprot[1] && !g1 |-> prdata[9:0] == GAS_SPURIOUS_ID ##1 !ack_pulse; endproperty
    a_none: assert property (p_none) else $error("spurious id wrong");
    property p_drop; drop_pulse |-> $past(psel && penable && pwrite && paddr == GAS_OFF_EOS && !pprot[1]); endproperty
    a_drop: assert property (p_drop) else $error("drop without write");
    property p_deact; deactivate_pulse |-> drop_pulse; endproperty
    a_deact: assert property (p_deact) else $error("lone deactivate");
    property p_eos; drop_pulse |-> eos_id == $past(pwdata[9:0]); endproperty
    a_eos: assert property (p_eos) else $error("end id wrong");
endmodule // gas_monitor
bind gas_alias_regs gas_monitor gas_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pprot, .prdata, .pend_valid, .pend_group1, .pend_id, .ack_pulse, .ack_id, .drop_pulse, .deactivate_pulse, .eos_id);
`default_nettype wire

// File: gas_pend_model.sv
// Interrupt source model: one pending interrupt that stays until acknowledged.
`default_nettype none
module gas_pend_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raise,
    input  wire logic ack_pulse,
    output logic      pend_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // An acknowledged interrupt turns active, so a second read must not see it again.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pend_valid <= 1'b0;
        else if (raise)
            pend_valid <= 1'b1;
        else if (ack_pulse)
            pend_valid <= 1'b0;
    end
endmodule // gas_pend_model
`default_nettype wire

// File: test_group1_alias_cpu_regs.sv
// Testbench for the group 1 alias register block.
`default_nettype none
module test_group1_alias_cpu_regs;
    import gas_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pend_group1 = 0, raise = 0;
    logic        pready, pslverr, pend_valid, ack_pulse, drop_pulse, deactivate_pulse;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0]  pprot = 0, pend_source = 0, ack_source, eos_source;
    logic [9:0]  pend_id = 0, ack_id, eos_id;
    logic [7:0]  pend_priority = 8'hff, group_priority;
    int          miscompares = 0, num_checks = 0, acks = 0, drops = 0, deacts = 0;
    gas_alias_regs gas_alias_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata,
        .pready, .pslverr, .pend_valid, .pend_group1, .pend_id, .pend_source, .pend_priority, .ack_pulse, .ack_id,
        .ack_source, .drop_pulse, .deactivate_pulse, .eos_id, .eos_source, .group_priority);
    gas_pend_model gas_pend_model_i (.pclk, .presetn, .raise, .ack_pulse, .pend_valid);
    initial forever #4 pclk = ~pclk;
    // Pulses are counted on the falling edge, away from the edge that launches them.
    always @(negedge pclk) begin
        acks += ack_pulse;
        drops += drop_pulse;
        deacts += deactivate_pulse;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ns);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pprot <= {1'b0, ns, 1'b0};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, GAS_OFF_SPLIT, 0, 0);
        chk("split reset", rd, 32'h1);
        apb(1, GAS_OFF_SPLIT, 32'hfffffffe, 0);
        apb(0, GAS_OFF_SPLIT, 0, 0);
        chk("split", rd, 32'h6);
        chk("group prio", group_priority, 8'h80);
        pend_group1 <= 1'b1;
        apb(1, GAS_OFF_CTRL, 32'h9, 0);
        // The control write lands at the edge that ends the transfer, so look once it has settled.
        @(negedge pclk);
        chk("group1 prio", group_priority, 8'hc0);
        for (int i = 0; i < 2; i++) begin
            pend_id <= i ? 10'h028 : 10'h005;
            pend_source <= 3'h3;
            raise <= 1'b1;
            @(posedge pclk);
            raise <= 1'b0;
            apb(0, GAS_OFF_ACK, 0, 1);
            chk("ns ack", rd, 32'h0);
            apb(0, GAS_OFF_ACK, 0, 0);
            chk("ack", rd, i ? 32'h28 : 32'hc05);
            apb(1, GAS_OFF_EOS, rd, 0);
        end
        apb(0, GAS_OFF_ACK, 0, 0);
        chk("spurious", rd, 32'h3ff);
        chk("acks", acks, 2);
        chk("drops", drops, 2);
        chk("deacts", deacts, 2);
        chk("end id", eos_id, 10'h028);
        apb(1, GAS_OFF_CTRL, 32'hd, 0);
        apb(1, GAS_OFF_EOS, 32'h28, 0);
        apb(1, GAS_OFF_CTRL, 32'hb, 0);
        apb(1, GAS_OFF_EOS, 32'h28, 0);
        apb(0, 12'h0fc, 0, 0);
        chk("unmapped", rd, 32'h0);
        apb(0, GAS_OFF_STATUS, 0, 1);
        chk("status", rd, 32'h28);
        chk("drops mode", drops, 3);
        chk("deacts mode", deacts, 2);
        tally_and_finish();
    end
endmodule // test_group1_alias_cpu_regs
`default_nettype wire
